// ==== common/cfe_map.svh ====
// constants for the fetch and execute pipeline
`ifndef CFE_MAP_SVH
`define CFE_MAP_SVH
// address the fetch unit reads the start address from
`define CFE_RESET_VEC_ADDR 32'h0000_0000
// base of the trap vector table, one quad per entry
`define CFE_TRAP_VEC_BASE 32'h0000_0040
// upper address half that selects the internal bus (bus 0)
`define CFE_INT_BUS_TAG 16'hffff
`define CFE_SP_IDX 4'hf
`define CFE_FP_IDX 4'he
`define CFE_STACK_STEP 32'h0000_0004
`define CFE_WORD_STEP 32'h0000_0002
`define CFE_LEA_NEXT_DISP 16'h0004
// opcode word fields
`define CFE_F_CLASS 15:12
`define CFE_F_RD 11:8
`define CFE_F_RS 7:4
`define CFE_F_SIZE 3:2
`define CFE_F_SGN 1
`define CFE_F_LONG 0
`define CFE_F_VEC 3:0
`endif

// ==== common/cfe_pkg.sv ====
// types for the fetch and execute pipeline
`default_nettype none
package cfe_pkg;
  typedef enum logic [3:0] {
    CL_NOP = 4'h0, CL_ADD = 4'h1, CL_LDI = 4'h2, CL_LDM = 4'h3, CL_STM = 4'h4, CL_LEA = 4'h5,
    CL_JR = 4'h6, CL_PUSH = 4'h7, CL_POP = 4'h8, CL_TRAP = 4'h9, CL_LDF = 4'ha
  } cfe_class_t;
  typedef enum logic [1:0] {SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_QUAD = 2'h2} cfe_size_t;
  typedef enum logic [2:0] {FT_VEC = 3'h1, FT_OP = 3'h2, FT_EXT = 3'h4} cfe_fetch_state_t;
  typedef enum logic [2:0] {EX_RUN = 3'h1, EX_REQ = 3'h2, EX_WAIT = 3'h4} cfe_exec_state_t;
endpackage : cfe_pkg
`default_nettype wire

// ==== design/cfe_pipeline.sv ====
// fetch unit, execution state machine, register file and bus arbiter
//
// What this block does
// - sixteen 32-bit registers, full-width operations
// - memory operands of 8, 16 or 32 bits
// - fetch opcode, decode length, fetch rest, hand over
// - one to three words, even start address
// - fetch unit reads the vectors
// - fetch next instruction while current executes
// - pc advances by fetched bytes; adder makes jumps
// - pc loaded from reset vector location
// - pc not an operand; lea 4(pc) gives next
// - execution machine forms addresses, sequences data accesses
// - narrow loads zero or sign extended
// - narrow stores keep only low bits
// - register fifteen is the stack pointer
// - register fourteen is the frame pointer
// - fetch time is (waits+1) times bytes over width
// - instruction byte count is 2, 4 or 6
// - bus width one or two bytes
// - per-bus wait states added to every access
// - immediates come with the fetch, no execute cycles
// - same bus conflict goes to execution unit
// - different buses serve fetch and data together
`timescale 1ns/10ps
`default_nettype none
`include "cfe_map.svh"

module cfe_pipeline (
  input wire logic clock,
  input wire logic srst,
  input wire logic [1:0][31:0] memRdata,
  input wire logic [1:0][3:0] memWaits,
  input wire logic [1:0] memWide,
  output logic [1:0] memReq,
  output logic [1:0] memWe,
  output logic [1:0][31:0] memAddr,
  output logic [1:0][1:0] memSize,
  output logic [1:0][31:0] memWdata,
  output logic [1:0] memLast,
  output logic retireValid,
  output logic [31:0] retireAddr
);

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  function automatic logic busOf(input logic [31:0] a);
    return (a[31:16] != `CFE_INT_BUS_TAG);
  endfunction : busOf

  // access length from waits, size and width
  function automatic logic [7:0] accessCycles(input logic [3:0] ws, input logic [1:0] sz, input logic wide);
    logic [2:0] beats;
    beats = 3'h1;
    // one or two bytes per beat
    if (wide) begin
      beats = (sz == cfe_pkg::SZ_QUAD) ? 3'h2 : 3'h1;
    end else begin
      beats = (sz == cfe_pkg::SZ_QUAD) ? 3'h4 : ((sz == cfe_pkg::SZ_WORD) ? 3'h2 : 3'h1);
    end
    return ({4'h0, ws} + 8'h01) * {5'h00, beats};
  endfunction : accessCycles

  // length in words from the opcode word
  function automatic logic [1:0] instrWords(input logic [15:0] op);
    logic [1:0] n;
    unique case (op[`CFE_F_CLASS])
      cfe_pkg::CL_LDI: n = op[`CFE_F_LONG] ? 2'h3 : 2'h2;
      cfe_pkg::CL_LDM, cfe_pkg::CL_STM, cfe_pkg::CL_LEA, cfe_pkg::CL_JR, cfe_pkg::CL_LDF: n = 2'h2;
      default: n = 2'h1;
    endcase
    return n;
  endfunction : instrWords

  function automatic logic [31:0] extend(input logic [31:0] d, input logic [1:0] sz, input logic sgn);
    logic [31:0] r;
    unique case (sz)
      cfe_pkg::SZ_BYTE: r = sgn ? {{24{d[7]}}, d[7:0]} : {24'h000000, d[7:0]};
      cfe_pkg::SZ_WORD: r = sgn ? {{16{d[15]}}, d[15:0]} : {16'h0000, d[15:0]};
      default: r = d;
    endcase
    return r;
  endfunction : extend

  // drop upper register bits on narrow stores
  function automatic logic [31:0] truncate(input logic [31:0] d, input logic [1:0] sz);
    logic [31:0] r;
    unique case (sz)
      cfe_pkg::SZ_BYTE: r = {24'h000000, d[7:0]};
      cfe_pkg::SZ_WORD: r = {16'h0000, d[15:0]};
      default: r = d;
    endcase
    return r;
  endfunction : truncate

  function automatic logic [31:0] pcAdd(input logic [31:0] base, input logic [15:0] disp);
    return base + {{16{disp[15]}}, disp};
  endfunction : pcAdd

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  cfe_pkg::cfe_fetch_state_t fetchState;
  cfe_pkg::cfe_exec_state_t execState;
  cfe_pkg::cfe_class_t slotClass;
  logic [31:0] regs [16];
  logic [31:0] fetchPc, vecAddr, instrAddr, extData;
  logic [15:0] curOp, slotOp;
  logic [31:0] slotExt, slotAddr;
  logic [1:0] extCnt, owner;
  logic [7:0] cnt [2];
  logic fetchBusy, fetchDrop, fetchBusSel, slotValid;
  logic [31:0] exAddr, exWdata, exInstrAddr;
  logic [1:0] exSize;
  logic [3:0] exRd;
  logic exWrite, exSigned, exPop;
  logic fetchWant, fetchBus, execWant, execBus, fetchGo, execGo;
  logic [31:0] fetchAddr, fetchData, execData, target, trapVec;
  logic [1:0] fetchSize, grantExec, grantFetch, done;
  logic [7:0] startCycles [2];
  logic fetchDone, execDone, fillSlot, takeSlot, redirect, trapReq, flush, memClass;
  logic [3:0] rd, rs;
  logic wrEn, spEn;
  logic [3:0] wrIdx;
  logic [31:0] wrData, spData;

  // ----------------------------------------------------------------
  // bus arbiter and access engines
  // ----------------------------------------------------------------
  // request side of both units
  always_comb begin
    fetchAddr = (fetchState == cfe_pkg::FT_VEC) ? vecAddr : fetchPc;
    fetchBus = busOf(fetchAddr);
    fetchSize = (fetchState == cfe_pkg::FT_VEC) ? cfe_pkg::SZ_QUAD : cfe_pkg::SZ_WORD;
    // no new opcode while the slot is held
    fetchWant = !fetchBusy && ((fetchState == cfe_pkg::FT_OP) ? !slotValid : 1'b1);
    execWant = (execState == cfe_pkg::EX_REQ);
    execBus = busOf(exAddr);
  end

  // per-bus grant; an idle bus only
  always_comb begin
    grantExec = 2'b00;
    grantFetch = 2'b00;
    for (int b = 0; b < 2; b++) begin
      startCycles[b] = accessCycles(memWaits[b], execWant && execBus == b[0] ? exSize : fetchSize, memWide[b]);
      if (!memReq[b]) begin
        // execution unit wins a shared bus
        if (execWant && execBus == b[0]) begin
          grantExec[b] = 1'b1;
        // fetch may use the other bus
        end else if (fetchWant && fetchBus == b[0]) begin
          grantFetch[b] = 1'b1;
        end
      end
    end
    fetchGo = |grantFetch;
    execGo = |grantExec;
    done = memReq & memLast;
    fetchDone = |(done & ~owner);
    execDone = |(done & owner);
    fetchData = memRdata[fetchBusSel];
    execData = memRdata[execBus];
  end

  // access engines hold the request for the whole access
  always_ff @(posedge clock) begin
    if (srst) begin
      memReq <= 2'b00;
      memWe <= 2'b00;
      memLast <= 2'b00;
      owner <= 2'b00;
      memAddr <= '0;
      memSize <= '0;
      memWdata <= '0;
      cnt[0] <= 8'h00;
      cnt[1] <= 8'h00;
    end else begin
      for (int b = 0; b < 2; b++) begin
        if (grantExec[b] || grantFetch[b]) begin
          memReq[b] <= 1'b1;
          owner[b] <= grantExec[b];
          memAddr[b] <= grantExec[b] ? exAddr : fetchAddr;
          memWe[b] <= grantExec[b] && exWrite;
          memSize[b] <= grantExec[b] ? exSize : fetchSize;
          memWdata[b] <= grantExec[b] ? exWdata : 32'h0000_0000;
          cnt[b] <= startCycles[b] - 8'h01;
          memLast[b] <= (startCycles[b] == 8'h01);
        end else if (memReq[b]) begin
          if (memLast[b]) begin
            memReq[b] <= 1'b0;
            memWe[b] <= 1'b0;
            memLast[b] <= 1'b0;
          end else begin
            cnt[b] <= cnt[b] - 8'h01;
            memLast[b] <= (cnt[b] == 8'h01);
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // fetch unit
  // ----------------------------------------------------------------
  // slot fill on the last word of an instruction
  always_comb begin
    fillSlot = fetchDone && !fetchDrop && !flush &&
      (((fetchState == cfe_pkg::FT_OP) && instrWords(fetchData[15:0]) == 2'h1) ||
       ((fetchState == cfe_pkg::FT_EXT) && extCnt == 2'h1));
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      // first read is the reset vector
      fetchState <= cfe_pkg::FT_VEC;
      vecAddr <= `CFE_RESET_VEC_ADDR;
      fetchPc <= 32'h0000_0000;
      fetchBusy <= 1'b0;
      fetchBusSel <= 1'b0;
      fetchDrop <= 1'b0;
      curOp <= 16'h0000;
      instrAddr <= 32'h0000_0000;
      extData <= 32'h0000_0000;
      extCnt <= 2'h0;
    end else begin
      if (fetchGo) begin
        fetchBusy <= 1'b1;
        fetchBusSel <= fetchBus;
      end else if (fetchDone) begin
        fetchBusy <= 1'b0;
      end
      if (flush) begin
        // an access already started is finished and thrown away
        fetchDrop <= (fetchBusy && !fetchDone) || fetchGo;
        // trap vector read by the fetch unit
        fetchState <= trapReq ? cfe_pkg::FT_VEC : cfe_pkg::FT_OP;
        vecAddr <= trapVec;
        if (redirect) begin
          fetchPc <= {target[31:1], 1'b0};
        end
      end else if (fetchDone && fetchDrop) begin
        fetchDrop <= 1'b0;
      end else if (fetchDone) begin
        unique case (fetchState)
          cfe_pkg::FT_VEC: begin
            fetchPc <= {fetchData[31:1], 1'b0};
            fetchState <= cfe_pkg::FT_OP;
          end
          cfe_pkg::FT_OP: begin
            curOp <= fetchData[15:0];
            instrAddr <= fetchPc;
            // pc steps by the bytes read
            fetchPc <= fetchPc + `CFE_WORD_STEP;
            extCnt <= instrWords(fetchData[15:0]) - 2'h1;
            extData <= 32'h0000_0000;
            fetchState <= (instrWords(fetchData[15:0]) == 2'h1) ? cfe_pkg::FT_OP : cfe_pkg::FT_EXT;
          end
          cfe_pkg::FT_EXT: begin
            extData <= {extData[15:0], fetchData[15:0]};
            fetchPc <= fetchPc + `CFE_WORD_STEP;
            extCnt <= extCnt - 2'h1;
            if (extCnt == 2'h1) begin
              fetchState <= cfe_pkg::FT_OP;
            end
          end
        endcase
      end
    end
  end

  // holding slot between fetch and execution
  always_ff @(posedge clock) begin
    if (srst) begin
      slotValid <= 1'b0;
      slotOp <= 16'h0000;
      slotExt <= 32'h0000_0000;
      slotAddr <= 32'h0000_0000;
    end else if (flush) begin
      slotValid <= 1'b0;
    end else if (fillSlot) begin
      slotValid <= 1'b1;
      slotOp <= (fetchState == cfe_pkg::FT_OP) ? fetchData[15:0] : curOp;
      slotExt <= {extData[15:0], fetchData[15:0]};
      slotAddr <= (fetchState == cfe_pkg::FT_OP) ? fetchPc : instrAddr;
    end else if (takeSlot) begin
      slotValid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // execution state machine
  // ----------------------------------------------------------------
  // decode of the held instruction
  always_comb begin
    slotClass = cfe_pkg::cfe_class_t'(slotOp[`CFE_F_CLASS]);
    rd = slotOp[`CFE_F_RD];
    rs = slotOp[`CFE_F_RS];
    // slot freed at start, so fetch overlaps execution
    takeSlot = (execState == cfe_pkg::EX_RUN) && slotValid;
    redirect = takeSlot && slotClass == cfe_pkg::CL_JR;
    trapReq = takeSlot && slotClass == cfe_pkg::CL_TRAP;
    flush = redirect || trapReq;
    // relative target from the pc adder
    target = pcAdd(slotAddr, slotExt[15:0]);
    trapVec = `CFE_TRAP_VEC_BASE + {26'h0000000, slotOp[`CFE_F_VEC], 2'b00};
    memClass = slotClass inside {cfe_pkg::CL_LDM, cfe_pkg::CL_LDF, cfe_pkg::CL_STM, cfe_pkg::CL_PUSH,
      cfe_pkg::CL_POP};
  end

  // address generation and data access sequencing
  always_ff @(posedge clock) begin
    if (srst) begin
      execState <= cfe_pkg::EX_RUN;
      exAddr <= 32'h0000_0000;
      exWdata <= 32'h0000_0000;
      exInstrAddr <= 32'h0000_0000;
      exSize <= cfe_pkg::SZ_QUAD;
      exRd <= 4'h0;
      exWrite <= 1'b0;
      exSigned <= 1'b0;
      exPop <= 1'b0;
    end else begin
      unique case (execState)
        cfe_pkg::EX_RUN: begin
          if (takeSlot && memClass) begin
            execState <= cfe_pkg::EX_REQ;
            exInstrAddr <= slotAddr;
            exRd <= rd;
            exPop <= (slotClass == cfe_pkg::CL_POP);
            exWrite <= slotClass inside {cfe_pkg::CL_STM, cfe_pkg::CL_PUSH};
            exSize <= slotOp[`CFE_F_SIZE];
            exSigned <= slotOp[`CFE_F_SGN];
            exWdata <= truncate(regs[rd], slotOp[`CFE_F_SIZE]);
            exAddr <= pcAdd(regs[rs], slotExt[15:0]);
            if (slotClass == cfe_pkg::CL_LDF) begin
              exAddr <= pcAdd(regs[`CFE_FP_IDX], slotExt[15:0]);
            end
            // stack pointer addresses push and pop
            if (slotClass == cfe_pkg::CL_PUSH) begin
              exAddr <= regs[`CFE_SP_IDX] - `CFE_STACK_STEP;
              exWdata <= regs[rs];
              exSize <= cfe_pkg::SZ_QUAD;
            end else if (slotClass == cfe_pkg::CL_POP) begin
              exAddr <= regs[`CFE_SP_IDX];
              exSize <= cfe_pkg::SZ_QUAD;
            end
          end
        end
        cfe_pkg::EX_REQ: begin
          if (execGo) begin
            execState <= cfe_pkg::EX_WAIT;
          end
        end
        cfe_pkg::EX_WAIT: begin
          if (execDone) begin
            execState <= cfe_pkg::EX_RUN;
          end
        end
      endcase
    end
  end

  // register write selection
  always_comb begin
    wrEn = 1'b0;
    wrIdx = rd;
    wrData = 32'h0000_0000;
    spEn = 1'b0;
    spData = regs[`CFE_SP_IDX] - `CFE_STACK_STEP;
    if (takeSlot) begin
      unique case (slotClass)
        cfe_pkg::CL_ADD: begin
          wrEn = 1'b1;
          wrData = regs[rd] + regs[rs];
        end
        cfe_pkg::CL_LDI: begin
          wrEn = 1'b1;
          wrData = slotOp[`CFE_F_LONG] ? slotExt : {{16{slotExt[15]}}, slotExt[15:0]};
        end
        // pc reachable only through this form
        cfe_pkg::CL_LEA: begin
          wrEn = 1'b1;
          wrData = pcAdd(slotAddr, slotExt[15:0]);
        end
        cfe_pkg::CL_PUSH: spEn = 1'b1;
        default: wrEn = 1'b0;
      endcase
    end else if (execDone && !exWrite) begin
      wrEn = 1'b1;
      wrIdx = exRd;
      wrData = extend(execData, exSize, exSigned);
      spEn = exPop;
      spData = regs[`CFE_SP_IDX] + `CFE_STACK_STEP;
    end
  end

  // register file; a popped stack pointer takes the loaded value
  always_ff @(posedge clock) begin
    if (srst) begin
      for (int i = 0; i < 16; i++) begin
        regs[i] <= 32'h0000_0000;
      end
    end else begin
      if (spEn) begin
        regs[`CFE_SP_IDX] <= spData;
      end
      if (wrEn) begin
        regs[wrIdx] <= wrData;
      end
    end
  end

  // retirement report
  always_ff @(posedge clock) begin
    if (srst) begin
      retireValid <= 1'b0;
      retireAddr <= 32'h0000_0000;
    end else begin
      retireValid <= (takeSlot && !memClass) || execDone;
      retireAddr <= execDone ? exInstrAddr : slotAddr;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [7:0] busCount0, busExpect0;

  // cycles spent in the current bus 0 access
  always_ff @(posedge clock) begin
    if (srst) begin
      busCount0 <= 8'h00;
      busExpect0 <= 8'h00;
    end else if (grantExec[0] || grantFetch[0]) begin
      busCount0 <= 8'h01;
      busExpect0 <= accessCycles(memWaits[0], grantExec[0] ? exSize : fetchSize, memWide[0]);
    end else if (memReq[0]) begin
      busCount0 <= busCount0 + 8'h01;
    end
  end

  chk_access_length: assert property (@(posedge clock) disable iff (srst)
    (memReq[0] && memLast[0]) |-> (busCount0 == busExpect0))
    else $error("bus 0 access length differs from wait-state formula");

  chk_exec_priority: assert property (@(posedge clock) disable iff (srst)
    (execWant && fetchWant && execBus == fetchBus && !memReq[execBus]) |=> (!fetchBusy && execState == cfe_pkg::EX_WAIT))
    else $error("fetch granted over execution unit");

  chk_dual_bus: assert property (@(posedge clock) disable iff (srst)
    (execWant && fetchWant && execBus != fetchBus && memReq == 2'b00) |=> (memReq == 2'b11 && fetchBusy))
    else $error("fetch and data not served together on separate buses");

  chk_pc_advance: assert property (@(posedge clock) disable iff (srst)
    (fetchDone && !fetchDrop && !flush && fetchState != cfe_pkg::FT_VEC) |=> (fetchPc == $past(fetchPc) + 32'h0000_0002))
    else $error("fetch pc did not advance by two");

  chk_slot_hold: assert property (@(posedge clock) disable iff (srst)
    (slotValid && !takeSlot && !flush) |=> (slotValid && $stable(slotOp) && $stable(slotAddr)))
    else $error("held instruction lost or changed");

  chk_store_trunc: assert property (@(posedge clock) disable iff (srst)
    (memReq[1] && memWe[1] && memSize[1] == cfe_pkg::SZ_BYTE) |-> (memWdata[1][31:8] == 24'h000000))
    else $error("byte store carries upper bits");

  chk_even_fetch: assert property (@(posedge clock) disable iff (srst)
    (fetchGo && fetchState != cfe_pkg::FT_VEC) |-> !fetchPc[0])
    else $error("instruction fetch from odd address");

  chk_reset_vec: assert property (@(posedge clock) disable iff (srst)
    $fell(srst) |-> (fetchState == cfe_pkg::FT_VEC && vecAddr == `CFE_RESET_VEC_ADDR && !slotValid))
    else $error("pc not sourced from reset vector");

  chk_lea_next: assert property (@(posedge clock) disable iff (srst)
    (takeSlot && slotClass == cfe_pkg::CL_LEA && slotExt[15:0] == `CFE_LEA_NEXT_DISP) |=>
    (regs[$past(rd)] == $past(slotAddr) + 32'h0000_0004))
    else $error("lea 4(pc) did not give next instruction address");

  chk_sign_extend: assert property (@(posedge clock) disable iff (srst)
    (execDone && !exWrite && exSigned && exSize == cfe_pkg::SZ_BYTE) |-> (wrData[31:8] == {24{wrData[7]}}))
    else $error("signed byte load not sign extended");

endmodule : cfe_pipeline
`default_nettype wire

// ==== dv/cfe_mem_model.sv ====
// memory on both buses, answering by timing alone
`timescale 1ns/10ps
`default_nettype none
module cfe_mem_model (
  input wire logic clock,
  input wire logic [1:0] memReq,
  input wire logic [1:0] memWe,
  input wire logic [1:0][31:0] memAddr,
  input wire logic [1:0][1:0] memSize,
  input wire logic [1:0][31:0] memWdata,
  input wire logic [1:0] memLast,
  output var logic [1:0][31:0] memRdata
);
  logic [7:0] mem [logic [31:0]];
  logic [31:0] noise = 32'h0;
  function automatic int nBytes(input logic [1:0] s);
    return (s == 2'h2) ? 4 : (s == 2'h1) ? 2 : 1;
  endfunction : nBytes
  function automatic logic [7:0] rd8(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : 8'h00;
  endfunction : rd8
  // high byte sits at the lower address
  function automatic logic [31:0] rdq(input logic [31:0] a, input logic [1:0] s);
    logic [31:0] q;
    q = {rd8(a), rd8(a + 32'h1), rd8(a + 32'h2), rd8(a + 32'h3)};
    return q >> (8 * (4 - nBytes(s)));
  endfunction : rdq
  task automatic put16(input logic [31:0] a, input logic [15:0] v);
    mem[a] = v[15:8];
    mem[a + 32'h1] = v[7:0];
  endtask : put16
  // idle lines carry a pattern that moves every cycle
  always @(posedge clock) begin
    noise <= noise + 32'h9e37_79b9;
  end
  // stores commit in the last cycle of the access
  always @(posedge clock) begin
    for (int b = 0; b < 2; b++) begin
      for (int i = 0; i < nBytes(memSize[b]); i++) begin
        if (memReq[b] && memWe[b] && memLast[b]) begin
          mem[memAddr[b] + 32'(i)] = 8'(memWdata[b] >> (8 * (nBytes(memSize[b]) - 1 - i)));
        end
      end
    end
  end
  // read data valid for the whole access
  always @* begin
    for (int b = 0; b < 2; b++) begin
      memRdata[b] = memReq[b] ? rdq(memAddr[b], memSize[b]) : noise ^ 32'(b);
    end
  end
endmodule : cfe_mem_model
`default_nettype wire

// ==== dv/tb_cfe_pipeline.sv ====
// self-checking bench for the fetch and execute pipeline
`timescale 1ns/10ps
`default_nettype none
module tb_cfe_pipeline;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [1:0][31:0] memRdata;
  logic [1:0][3:0] memWaits = 8'h00;
  logic [1:0] memWide = 2'h0;
  logic [1:0] memReq, memWe, memLast;
  logic [1:0] prevLast = 2'h0;
  logic [1:0][31:0] memAddr, memWdata;
  logic [1:0][1:0] memSize;
  logic retireValid;
  logic [31:0] retireAddr;
  logic [31:0] rnd = 32'h9;
  logic [31:0] retQ[$];
  logic [65:0] wrQ[$];
  logic [31:0] img[$] = '{32'h0000_0000, 32'h0002_0100, 32'h0044_0000, 32'h0046_0200,
    32'h0100_2101, 32'h0102_8765, 32'h0104_43a1, 32'h0106_5200, 32'h0108_0004,
    32'h010a_4120, 32'h010c_0200, 32'h010e_3322, 32'h0110_0200, 32'h0112_7030,
    32'h0114_4124, 32'h0116_0200, 32'h0118_9001, 32'h0200_1130, 32'h0202_6000, 32'h0204_0000};
  int nMismatch = 0;
  int numChecks = 0;
  int cycles = 0;
  int cnt[2] = '{0, 0};

  always #2 clock = ~clock;

  cfe_pipeline i_cfe_pipeline (.clock(clock), .srst(srst), .memRdata(memRdata), .memWaits(memWaits),
    .memWide(memWide), .memReq(memReq), .memWe(memWe), .memAddr(memAddr), .memSize(memSize),
    .memWdata(memWdata), .memLast(memLast), .retireValid(retireValid), .retireAddr(retireAddr));
  cfe_mem_model i_cfe_mem_model (.clock(clock), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
    .memSize(memSize), .memWdata(memWdata), .memLast(memLast), .memRdata(memRdata));

  task automatic check(input string what, input logic [65:0] expv, input logic [65:0] got);
    numChecks++;
    if (expv !== got) begin
      nMismatch++;
      $display("mismatch %s expected %h seen %h", what, expv, got);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", numChecks, nMismatch);
    if (nMismatch == 0 && numChecks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  // access length from waits, width and size
  function automatic logic [65:0] expLen(input int b);
    logic [6:0] beats;
    beats = memWide[b] ? ((memSize[b] == 2'h2) ? 7'h2 : 7'h1) :
      ((memSize[b] == 2'h2) ? 7'h4 : (memSize[b] == 2'h1) ? 7'h2 : 7'h1);
    return 66'(beats * (7'(memWaits[b]) + 7'h1));
  endfunction : expLen

  // ------------------------------------------------------------
  // watcher: bus timing, stores and retirements
  // ------------------------------------------------------------
  always @(posedge clock) begin
    cycles++;
    if (cycles > 20000) begin
      nMismatch++;
      give_verdict();
    end
    for (int b = 0; b < 2; b++) begin
      if (srst) begin
        cnt[b] = 0;
      end else begin
        if (prevLast[b]) check("memReqDrop", 66'h0, 66'(memReq[b]));
        if (memLast[b] === 1'b1) begin
          check("accessLength", expLen(b), 66'(cnt[b]) + 66'(memReq[b]));
          if (memWe[b] === 1'b1) check("store", wrQ.size() > 0 ? wrQ.pop_front() : 66'h0,
            {memSize[b], memAddr[b], memWdata[b]});
        end
        cnt[b] = (memReq[b] === 1'b1) ? cnt[b] + 1 : 0;
      end
      prevLast[b] = (memLast[b] === 1'b1) && !srst;
    end
    if (!srst && retireValid === 1'b1 && retQ.size() > 0) check("retireAddr", 66'(retQ.pop_front()),
      66'(retireAddr));
  end

  // ------------------------------------------------------------
  // main sequence: one program under random bus settings
  // ------------------------------------------------------------
  initial begin
    foreach (img[i]) i_cfe_mem_model.put16({16'h0000, img[i][31:16]}, img[i][15:0]);
    for (int run = 0; run < 4; run++) begin
      @(negedge clock);
      srst = 1'b1;
      rnd ^= rnd << 13;
      rnd ^= rnd >> 17;
      rnd ^= rnd << 5;
      memWaits = {2'h0, rnd[3:2], 2'h0, rnd[1:0]};
      memWide = rnd[5:4];
      // one to three words per instruction
      retQ = '{32'h100, 32'h106, 32'h10a, 32'h10e, 32'h112, 32'h114, 32'h118, 32'h200, 32'h202, 32'h202};
      // widened load, narrow stores, stack push
      wrQ = '{{2'h0, 32'h30a, 32'ha1}, {2'h2, 32'hffff_fffc, 32'hffff_ffa1}, {2'h1, 32'h30a, 32'h43a1}};
      repeat (3) @(negedge clock);
      srst = 1'b0;
      repeat (2) @(posedge clock);
      #1;
      check("vectorRead", 66'({1'b1, 2'h2, 32'h0}), 66'({memReq[1], memSize[1], memAddr[1]}));
      for (int k = 0; k < 3000 && retQ.size() > 0; k++) @(posedge clock);
      check("retirePending", 66'h0, 66'(retQ.size()));
      check("storePending", 66'h0, 66'(wrQ.size()));
    end
    give_verdict();
  end
endmodule : tb_cfe_pipeline
`default_nettype wire
